// *** design/hbw_defines.svh ***
/*
  Constants of the multiplexed host write port: widths, field positions,
  byte-lane codes and timing counts.
  Assumes inclusion by its bare name from the package and the modules.
*/
`ifndef HBW_DEFINES_SVH
`define HBW_DEFINES_SVH

`define HBW_AD_W 16
`define HBW_BE_W 2
`define HBW_PIN_W 5
`define HBW_SYNC_W (`HBW_PIN_W + `HBW_BE_W + `HBW_AD_W)
`define HBW_LO 7:0
`define HBW_HI 15:8
`define HBW_BYTE_ZERO 8'h00
`define HBW_WORD_ZERO 16'h0000

`define HBW_BE_ALL 2'h3
`define HBW_BE_LO 2'h1
`define HBW_BE_HI 2'h2

`define HBW_CLK_NS 25
`define HBW_W8_MAX_NS 200
`define HBW_W16_MAX_NS 280
`define HBW_CNT_W 4
`define HBW_W8_CYC `HBW_CNT_W'(`HBW_W8_MAX_NS / `HBW_CLK_NS)
`define HBW_W16_CYC `HBW_CNT_W'(`HBW_W16_MAX_NS / `HBW_CLK_NS)
`define HBW_CNT_ZERO 4'h0
`define HBW_CNT_ONE 4'h1
`define HBW_CNT_MAX 4'hF

`endif

// *** design/hbw_pkg.sv ***
/*
  Types of the multiplexed host write port: configuration, pin group,
  write request and cycle state.
  Assumes hbw_defines.svh is on the include path.
*/
`include "hbw_defines.svh"

package hbw_pkg;

  // Pin polarity, one means active high
  typedef struct packed {
    logic wait_hi;
    logic ale_hi;
    logic cs_hi;
    logic rd_hi;
    logic wr_hi;
  } hbw_pol_t;

  typedef struct packed {
    logic direct;
    logic posted;
    logic dir_strobe;
    logic wait_en;
    logic ale_qual;
    logic bus16;
    hbw_pol_t pol;
  } hbw_cfg_t;

  typedef struct packed {
    logic cs;
    logic rd;
    logic wr;
    logic lo_ale;
    logic hi_ale;
  } hbw_pins_t;

  typedef struct packed {
    logic [`HBW_AD_W-1:0] addr;
    logic [`HBW_AD_W-1:0] data;
    logic [`HBW_BE_W-1:0] be;
    logic is16;
  } hbw_wreq_t;

  typedef enum logic [1:0] {
    HBW_IDLE = 2'h0,
    HBW_STROBE = 2'h1,
    HBW_ACKED = 2'h3
  } hbw_state_t;

endpackage

// *** design/hbw_sync.sv ***
/*
  Two-stage synchroniser for a bundle of asynchronous pins.
  Assumes each bit is independent; multi-bit values are only read
  while the host holds them stable.
*/
`timescale 1ns/1ps
`include "hbw_defines.svh"

module hbw_sync #(
  parameter int WIDTH = `HBW_SYNC_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Pins and synchronised copy
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic meta_q;
      logic stab_q;
      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          meta_q <= 1'b0;
          stab_q <= 1'b0;
        end else begin
          meta_q <= async_i[gi];
          stab_q <= meta_q;
        end
      end
      assign sync_o[gi] = stab_q;
    end
  endgenerate

endmodule // hbw_sync

// *** design/hbw_addr_latch.sv ***
/*
  Address latch for single or dual phase multiplexed addressing.
  Assumes latch and select inputs are synchronised and active high.
*/
`timescale 1ns/1ps
`include "hbw_defines.svh"

module hbw_addr_latch (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Latch strobes and qualifiers
  input wire logic lo_act_i,
  input wire logic hi_act_i,
  input wire logic cs_act_i,
  input wire logic ale_qual_i,
  input wire logic bus16_i,
  // Address/data bus and latched address
  input wire logic [`HBW_AD_W-1:0] ad_i,
  output logic [`HBW_AD_W-1:0] addr_o
);

  logic [`HBW_AD_W-1:0] addr_q;
  logic [`HBW_AD_W-1:0] addr_d;
  wire gate_ok;
  wire lo_take;
  wire hi_take;

  assign gate_ok = ~ale_qual_i | cs_act_i;
  assign lo_take = lo_act_i & gate_ok;
  assign hi_take = hi_act_i & gate_ok;

  // On an 8-bit bus each phase writes its own half, so either order gives the same address; on a 16-bit bus the low phase writes both halves
  always_comb begin
    addr_d = addr_q;
    if (lo_take) begin
      addr_d[`HBW_LO] = ad_i[`HBW_LO];
      if (bus16_i) begin
        addr_d[`HBW_HI] = ad_i[`HBW_HI];
      end
    end
    if (hi_take) begin
      addr_d[`HBW_HI] = ad_i[`HBW_LO];
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      addr_q <= `HBW_WORD_ZERO;
    end else begin
      addr_q <= addr_d;
    end
  end

  assign addr_o = addr_q;

endmodule // hbw_addr_latch

// *** design/hbw_write_port.sv ***
/*
  Write side of a multiplexed 8/16-bit parallel host port: legacy mode,
  direct mapped posted and non-posted writes, separate or direction plus
  strobe signalling, and the cycle-hold output.
  Assumes pins are asynchronous to clk_i, cfg_i is static and synchronous,
  and the memory path answers each request with one wr_done_i pulse.
*/
`timescale 1ns/1ps
`include "hbw_defines.svh"

////////////////////////////////////////////////////////////////////////////

module hbw_write_port (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Static configuration
  input wire hbw_pkg::hbw_cfg_t cfg_i,
  // Host pins
  input wire logic cs_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic low_addr_latch_i,
  input wire logic high_addr_latch_i,
  input wire logic [`HBW_BE_W-1:0] byte_lane_selects_i,
  input wire logic [`HBW_AD_W-1:0] ad_i,
  // Cycle-hold pin
  output logic wait_ack_o,
  output logic wait_ack_oe_o,
  // Internal write path
  output logic wr_req_o,
  output hbw_pkg::hbw_wreq_t wr_req_data_o,
  input wire logic wr_done_i,
  // Deadline status
  output logic write_late_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Request builder

  function automatic hbw_pkg::hbw_wreq_t build_req(
    input logic [`HBW_AD_W-1:0] addr,
    input logic [`HBW_AD_W-1:0] data,
    input logic [`HBW_BE_W-1:0] lanes,
    input logic bus16,
    input logic legacy
  );
    hbw_pkg::hbw_wreq_t req;
    req.addr = addr;
    req.data = data;
    if (!bus16) begin
      req.data[`HBW_HI] = `HBW_BYTE_ZERO;
    end
    if (legacy) begin
      if (bus16) begin
        req.be = `HBW_BE_ALL;
      end else begin
        req.be = addr[0] ? `HBW_BE_HI : `HBW_BE_LO;
      end
    end else begin
      req.be = lanes;
    end
    req.is16 = bus16 & (req.be == `HBW_BE_ALL);
    return req;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and polarity

  hbw_pkg::hbw_pins_t pins_raw;
  hbw_pkg::hbw_pins_t pins_s;
  hbw_pkg::hbw_pins_t pins_a;
  logic [`HBW_BE_W-1:0] be_s;
  logic [`HBW_AD_W-1:0] ad_s;
  logic [`HBW_PIN_W-1:0] pol_mask;
  logic boot_q;
  logic live_q;

  assign pins_raw.cs = cs_i;
  assign pins_raw.rd = rd_i;
  assign pins_raw.wr = wr_i;
  assign pins_raw.lo_ale = low_addr_latch_i;
  assign pins_raw.hi_ale = high_addr_latch_i;

  hbw_sync #(
    .WIDTH(`HBW_SYNC_W)
  ) u_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .async_i({pins_raw, byte_lane_selects_i, ad_i}),
    .sync_o({pins_s, be_s, ad_s})
  );

  assign pol_mask = {cfg_i.pol.cs_hi, cfg_i.pol.rd_hi, cfg_i.pol.wr_hi,
                     cfg_i.pol.ale_hi, cfg_i.pol.ale_hi};
  // Pins read inactive until the synchroniser has flushed after reset
  assign pins_a = hbw_pkg::hbw_pins_t'((pins_s ^ ~pol_mask) & {`HBW_PIN_W{live_q}});

  ////////////////////////////////////////////////////////////////////////////
  // Address phase

  logic [`HBW_AD_W-1:0] addr_l;

  hbw_addr_latch u_addr (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .lo_act_i(pins_a.lo_ale),
    .hi_act_i(pins_a.hi_ale),
    .cs_act_i(pins_a.cs),
    .ale_qual_i(cfg_i.ale_qual),
    .bus16_i(cfg_i.bus16),
    .ad_i(ad_s),
    .addr_o(addr_l)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Mode and strobe decode

  wire legacy;
  wire posted;
  wire nonposted;
  wire cs_act;
  wire wstb;
  wire start;
  wire stop;
  logic wstb_q;

  assign legacy = ~cfg_i.direct;
  assign posted = cfg_i.direct & cfg_i.posted;
  assign nonposted = cfg_i.direct & ~cfg_i.posted;
  assign cs_act = pins_a.cs;

  // In direction mode the write pin is the bus strobe, the read pin the
  // direction line (active means read)
  assign wstb = cfg_i.dir_strobe ? (pins_a.wr & ~pins_a.rd) : pins_a.wr;

  // Select is sampled only at strobe assertion; it must not move meanwhile
  assign start = cs_act & wstb & ~wstb_q;
  assign stop = ~wstb & wstb_q;

  ////////////////////////////////////////////////////////////////////////////
  // Cycle state

  hbw_pkg::hbw_state_t state_q;
  hbw_pkg::hbw_state_t state_d;
  logic [`HBW_AD_W-1:0] data_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      hbw_pkg::HBW_IDLE: begin
        if (start) begin
          state_d = hbw_pkg::HBW_STROBE;
        end
      end
      hbw_pkg::HBW_STROBE: begin
        if (stop) begin
          state_d = hbw_pkg::HBW_IDLE;
        end else if (nonposted && wr_done_i) begin
          state_d = hbw_pkg::HBW_ACKED;
        end
      end
      hbw_pkg::HBW_ACKED: begin
        if (stop) begin
          state_d = hbw_pkg::HBW_IDLE;
        end
      end
      default: begin
        state_d = hbw_pkg::HBW_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write issue

  wire in_cycle;
  wire issue_start;
  wire issue_end;
  wire issue;
  hbw_pkg::hbw_wreq_t req_start;
  hbw_pkg::hbw_wreq_t req_end;
  hbw_pkg::hbw_wreq_t req_d;
  hbw_pkg::hbw_wreq_t req_q;
  logic req_q_v;

  assign in_cycle = (state_q != hbw_pkg::HBW_IDLE);

  // Address is settled before the strobe, so it is taken with the data
  assign req_start = build_req(addr_l, ad_s, be_s, cfg_i.bus16, legacy);
  assign req_end = build_req(addr_l, data_q, be_s, cfg_i.bus16, legacy);

  // Non-posted issues at strobe assertion, posted and legacy at release
  assign issue_start = start & nonposted & (state_q == hbw_pkg::HBW_IDLE);
  assign issue_end = in_cycle & stop & ~nonposted;
  assign issue = issue_start | issue_end;
  assign req_d = issue_start ? req_start : (issue ? req_end : req_q);

  ////////////////////////////////////////////////////////////////////////////
  // Pending posted write

  logic pend_q;
  logic pend16_q;
  wire pend_d;
  wire pend16_d;

  // A new post wins over a completion in the same cycle
  assign pend_d = (issue_end & posted) | (pend_q & ~wr_done_i);
  assign pend16_d = (issue_end & posted) ? req_end.is16 : pend16_q;

  ////////////////////////////////////////////////////////////////////////////
  // Cycle-hold

  wire hold_d;
  wire wait_d;
  wire oe_d;

  assign hold_d = cfg_i.direct &
                  (cfg_i.posted ? pend_d : (state_d == hbw_pkg::HBW_STROBE));
  assign wait_d = hold_d ^ ~cfg_i.pol.wait_hi;
  // Output enable follows select, so a joint release floats the pin
  assign oe_d = cfg_i.wait_en & cs_act;

  ////////////////////////////////////////////////////////////////////////////
  // Deadline watch

  logic [`HBW_CNT_W-1:0] cnt_q;
  logic [`HBW_CNT_W-1:0] cnt_d;
  logic [`HBW_CNT_W-1:0] limit;
  wire waiting;
  wire wait16;
  wire late_d;

  // The host relies on hold releasing in time while it keeps the strobe
  assign waiting = cfg_i.direct & wstb & in_cycle & hold_d;
  assign wait16 = cfg_i.posted ? pend16_q : req_q.is16;
  assign limit = wait16 ? `HBW_W16_CYC : `HBW_W8_CYC;
  assign late_d = waiting & (cnt_q == limit);

  always_comb begin
    if (!waiting) begin
      cnt_d = `HBW_CNT_ZERO;
    end else if (cnt_q == `HBW_CNT_MAX) begin
      cnt_d = cnt_q;
    end else begin
      cnt_d = cnt_q + `HBW_CNT_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= hbw_pkg::HBW_IDLE;
      wstb_q <= 1'b0;
      data_q <= `HBW_WORD_ZERO;
      req_q <= '0;
      req_q_v <= 1'b0;
      pend_q <= 1'b0;
      pend16_q <= 1'b0;
      cnt_q <= `HBW_CNT_ZERO;
      boot_q <= 1'b0;
      live_q <= 1'b0;
    end else begin
      state_q <= state_d;
      wstb_q <= wstb;
      data_q <= wstb ? ad_s : data_q;
      req_q <= req_d;
      req_q_v <= issue;
      pend_q <= pend_d;
      pend16_q <= pend16_d;
      cnt_q <= cnt_d;
      boot_q <= 1'b1;
      live_q <= boot_q;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wait_ack_o <= 1'b1;
      wait_ack_oe_o <= 1'b0;
      write_late_o <= 1'b0;
    end else begin
      wait_ack_o <= wait_d;
      wait_ack_oe_o <= oe_d;
      write_late_o <= late_d;
    end
  end

  assign wr_req_o = req_q_v;
  assign wr_req_data_o = req_q;

endmodule // hbw_write_port

// *** sim/hbw_write_port_assertions.sv ***
/* Pin-level checks of the host write port.
   Assumes bind to hbw_write_port and a static cfg_i. */
`timescale 1ns/1ps
module hbw_write_port_chk (
  // Clock, reset and config
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire hbw_pkg::hbw_cfg_t cfg_i,
  // Host pins
  input wire logic cs_i,
  input wire logic rd_i,
  input wire logic wr_i,
  // Port outputs and memory answer
  input wire logic wait_ack_o,
  input wire logic wait_ack_oe_o,
  input wire logic wr_req_o,
  input wire hbw_pkg::hbw_wreq_t wr_req_data_o,
  input wire logic wr_done_i,
  input wire logic write_late_o
);
  wire cs_a = cs_i ~^ cfg_i.pol.cs_hi;
  wire rd_a = rd_i ~^ cfg_i.pol.rd_hi;
  wire ws_a = (wr_i ~^ cfg_i.pol.wr_hi) & ~(cfg_i.dir_strobe & rd_a);
  wire hold = wait_ack_o ~^ cfg_i.pol.wait_hi;
  wire dp = cfg_i.direct & cfg_i.posted;
  wire dn = cfg_i.direct & ~cfg_i.posted;
  wire a0 = wr_req_data_o.addr[0];
  wire [1:0] lbe = cfg_i.bus16 ? 2'h3 : {a0, ~a0};
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  ////////////////////////////////////////////////////////////
  a_oe_on_sel: assert property ((cfg_i.wait_en && cs_a) [*3] |=> wait_ack_oe_o)
    else $error("hold pin not driven under select");
  a_oe_float: assert property ((!cs_a) [*3] |=> !wait_ack_oe_o)
    else $error("hold pin driven without select");
  a_legacy_idle: assert property (!cfg_i.direct && wait_ack_oe_o |-> !hold)
    else $error("hold active in legacy mode");
  a_legacy_lanes: assert property (!cfg_i.direct && wr_req_o |-> wr_req_data_o.be == lbe)
    else $error("legacy lanes not derived from address");
  a_posted_set: assert property (dp && $fell(ws_a) && cs_a |-> ##3 (wr_req_o && hold))
    else $error("posted write not marked pending");
  a_nonpost_set: assert property (dn && $rose(ws_a) && cs_a |-> ##3 (wr_req_o && hold))
    else $error("non-posted hold not raised");
  a_done_clears: assert property (cfg_i.direct && wr_done_i && !wr_req_o |-> ##2 !hold)
    else $error("hold kept after completion");
  a_no_sel_req: assert property ((!cs_a) [*5] |-> !wr_req_o)
    else $error("write taken without select");
  a_dir_read: assert property (cfg_i.dir_strobe && rd_a [*5] |-> !wr_req_o)
    else $error("write taken with read direction");
  a_req_once: assert property (wr_req_o |=> !wr_req_o)
    else $error("request longer than one cycle");
  a_late_pulse: assert property ($rose(write_late_o) |-> $past(hold) ##1 !write_late_o)
    else $error("late flag without hold");
  c_posted: cover property (dp && wr_req_o);
  c_nonpost: cover property (dn && wr_req_o);
  c_late: cover property (write_late_o);
endmodule // hbw_write_port_chk

bind hbw_write_port hbw_write_port_chk u_chk (.clk_i(clk_i), .rstn_i(rstn_i), .cfg_i(cfg_i),
  .cs_i(cs_i), .rd_i(rd_i), .wr_i(wr_i), .wait_ack_o(wait_ack_o), .wait_ack_oe_o(wait_ack_oe_o),
  .wr_req_o(wr_req_o), .wr_req_data_o(wr_req_data_o), .wr_done_i(wr_done_i),
  .write_late_o(write_late_o));

// *** sim/hbw_host_model.sv ***
/* Host processor model on the multiplexed bus, all pins active high.
   Assumes an active high hold level on wait_ack_o. */
`timescale 1ns/1ps
module hbw_host_model (
  // Clock
  input wire logic clk_i,
  // Hold pin from the port
  input wire logic wait_ack_o,
  input wire logic wait_ack_oe_o,
  // Host pins
  output logic cs_o,
  output logic rd_o,
  output logic wr_o,
  output logic lo_o,
  output logic hi_o,
  output logic [1:0] be_o,
  output logic [15:0] ad_o
);
  initial {cs_o, rd_o, wr_o, lo_o, hi_o, be_o, ad_o} = '0;
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  task automatic sel(input logic v);
    cs_o = v;
  endtask
  // Upper half carries junk on an 8-bit bus
  task automatic latch(input bit h, b16, input logic [15:0] a);
    ad_o = b16 ? a : h ? {~a[7:0], a[15:8]} : {~a[15:8], a[7:0]};
    if (h)
      hi_o = 1'b1;
    else
      lo_o = 1'b1;
    tick(3);
    {hi_o, lo_o} = 2'h0;
    tick(1);
  endtask
  task automatic write(input bit dir, b16, hf, drop, input logic [15:0] a, d,
                       input logic [1:0] be);
    int n;
    tick(1);
    cs_o = 1'b1;
    rd_o = 1'b0;
    latch(b16 ? 1'b0 : hf, b16, a);
    if (!b16)
      latch(!hf, b16, a);
    ad_o = d;
    be_o = be;
    wr_o = 1'b1;
    tick(4);
    if (!wait_ack_oe_o)
      tick(8);
    for (n = 0; n < 60 && wait_ack_oe_o && wait_ack_o; n++)
      tick(1);
    wr_o = 1'b0;
    if (drop)
      cs_o = 1'b0;
    tick(3);
    cs_o = 1'b0;
    rd_o = dir;
    ad_o = ~ad_o;
    be_o = ~be_o;
  endtask
endmodule // hbw_host_model

// *** sim/hbw_write_port_tb.sv ***
/* Self-checking bench of the host write port.
   Assumes the host model drives every pin and the bench answers requests. */
`timescale 1ns/1ps
module hbw_write_port_tb;
  typedef struct packed {
    logic [1:0] m;
    logic dir;
    logic b16;
    logic hf;
    logic [15:0] a;
    logic [15:0] d;
    logic [1:0] be;
    hbw_pkg::hbw_wreq_t exp;
  } hbw_row_t;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic wr_done_i = 1'b0;
  hbw_pkg::hbw_cfg_t cfg_i = 11'h01F;
  hbw_pkg::hbw_wreq_t wr_req_data, got;
  logic cs_i, rd_i, wr_i, lo_i, hi_i, wait_ack_o, wait_ack_oe_o, wr_req_o, write_late_o;
  logic h_cs, h_rd, h_wr, h_lo, h_hi;
  logic [1:0] be_i;
  logic [15:0] ad_i;
  int fails = 0, checks = 0, nreq = 0, nlate = 0, nhold = 0, dly = 6, n0, h0;
  hbw_row_t rows [6] = '{
    '{2'h0, 1'b0, 1'b1, 1'b0, 16'h1234, 16'hABCD, 2'h1, {16'h1234, 16'hABCD, 2'h3, 1'b1}},
    '{2'h0, 1'b1, 1'b0, 1'b1, 16'h5A01, 16'hC33C, 2'h3, {16'h5A01, 16'h003C, 2'h2, 1'b0}},
    '{2'h3, 1'b0, 1'b1, 1'b0, 16'h0F0E, 16'h8001, 2'h2, {16'h0F0E, 16'h8001, 2'h2, 1'b0}},
    '{2'h3, 1'b1, 1'b0, 1'b0, 16'h7702, 16'h11EE, 2'h1, {16'h7702, 16'h00EE, 2'h1, 1'b0}},
    '{2'h2, 1'b0, 1'b1, 1'b0, 16'hFFFE, 16'h5555, 2'h3, {16'hFFFE, 16'h5555, 2'h3, 1'b1}},
    '{2'h2, 1'b1, 1'b0, 1'b1, 16'h0480, 16'h9966, 2'h2, {16'h0480, 16'h0066, 2'h2, 1'b0}}};
  hbw_write_port uut (.clk_i(clk_i), .rstn_i(rstn_i), .cfg_i(cfg_i), .cs_i(cs_i), .rd_i(rd_i),
    .wr_i(wr_i), .low_addr_latch_i(lo_i), .high_addr_latch_i(hi_i), .byte_lane_selects_i(be_i),
    .ad_i(ad_i), .wait_ack_o(wait_ack_o), .wait_ack_oe_o(wait_ack_oe_o), .wr_req_o(wr_req_o),
    .wr_req_data_o(wr_req_data), .wr_done_i(wr_done_i), .write_late_o(write_late_o));
  hbw_host_model host (.clk_i(clk_i), .wait_ack_o(wait_ack_o ~^ cfg_i.pol.wait_hi),
    .wait_ack_oe_o(wait_ack_oe_o), .cs_o(h_cs), .rd_o(h_rd), .wr_o(h_wr), .lo_o(h_lo),
    .hi_o(h_hi), .be_o(be_i), .ad_o(ad_i));
  // Host works in active high levels, the pins follow the configured polarity
  assign cs_i = h_cs ~^ cfg_i.pol.cs_hi;
  assign rd_i = h_rd ~^ cfg_i.pol.rd_hi;
  assign wr_i = h_wr ~^ cfg_i.pol.wr_hi;
  assign lo_i = h_lo ~^ cfg_i.pol.ale_hi;
  assign hi_i = h_hi ~^ cfg_i.pol.ale_hi;
  always #12.5 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////
  // Memory path answers each request after dly cycles
  always @(posedge clk_i) begin
    if (wr_req_o === 1'b1) begin
      got <= wr_req_data;
      nreq <= nreq + 1;
      fork begin
        repeat (dly) @(posedge clk_i);
        #2 wr_done_i = 1'b1;
        @(posedge clk_i);
        #2 wr_done_i = 1'b0;
      end join_none
    end
    if (write_late_o === 1'b1)
      nlate <= nlate + 1;
    if (wait_ack_oe_o === 1'b1 && wait_ack_o === 1'b1)
      nhold <= nhold + 1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    fails++;
    wrap_up;
  end
  initial begin
    tick(20);
    chk({wait_ack_o, wait_ack_oe_o, wr_req_o, write_late_o}, 4'h8);
    rstn_i = 1'b1;
    tick(4);
    $display("reset test done");
    foreach (rows[i]) begin
      cfg_i = {rows[i].m, rows[i].dir, 2'h3, rows[i].b16, 5'h1F};
      n0 = nreq;
      host.write(rows[i].dir, rows[i].b16, rows[i].hf, 1'b0, rows[i].a, rows[i].d, rows[i].be);
      tick(12);
      chk(got, rows[i].exp);
      chk(nreq - n0, 1);
      $display("row %0d done", i);
    end
    cfg_i = 11'h6FF;
    dly = 20;
    host.sel(1'b1);
    tick(4);
    chk({wait_ack_oe_o, wait_ack_o}, 2'h2);
    host.write(1'b0, 1'b1, 1'b0, 1'b0, 16'h2468, 16'h1357, 2'h3);
    tick(1);
    host.sel(1'b1);
    tick(4);
    chk({wait_ack_oe_o, wait_ack_o}, 2'h3);
    host.write(1'b0, 1'b1, 1'b0, 1'b0, 16'h2469, 16'h0A0B, 2'h1);
    tick(4);
    chk(got, {16'h2469, 16'h0A0B, 2'h1, 1'b0});
    tick(25);
    $display("posted pair test done");
    dly = 6;
    h0 = nhold;
    n0 = nreq;
    host.write(1'b0, 1'b1, 1'b0, 1'b1, 16'h3000, 16'h00FF, 2'h3);
    tick(12);
    chk(nhold - h0, 0);
    chk(nreq - n0, 1);
    $display("joint release test done");
    rstn_i = 1'b0;
    cfg_i = 11'h5DA;
    dly = 14;
    n0 = nreq;
    tick(2);
    rstn_i = 1'b1;
    tick(2);
    chk({wait_ack_oe_o, wr_req_o, write_late_o}, 3'h0);
    chk(nreq - n0, 0);
    $display("second reset test done");
    n0 = nlate;
    host.write(1'b1, 1'b0, 1'b0, 1'b0, 16'h00AA, 16'h0077, 2'h1);
    tick(12);
    chk(nlate - n0, 1);
    chk(got, {16'h00AA, 16'h0077, 2'h1, 1'b0});
    $display("late test done");
    wrap_up;
  end
endmodule // hbw_write_port_tb
